/* logic/lpm_dev.sv */
/*
 * Low-power mode controller: normal, deep suspend, standby and core power-down,
 * wake detection, pad pull/hold/gpio configuration and per-interface drive strength.
 * Assumes wake pins synchronous-capable levels, an always-on ref_clk, and
 * core_vdd_on from the link standing for the core supply.
 */
`include "lpm_map.svh"

module lpm_dev (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    lpm_if.dev                               lnk,
    input  wire logic                        usb_dp,
    input  wire logic                        usb_dm,
    input  wire logic                        otg_id,
    input  wire logic                        vbus_det,
    input  wire logic                        uart_cts,
    input  wire logic                        parallel_control_line_zero,
    output logic                             usb3_phy_en,
    output logic                             usb_suspend,
    output logic                             clk_run,
    output logic                             pll_en,
    output logic                             xtal_en,
    output logic                             usb_xcvr_en,
    output logic                             cpu_pwr_en,
    output logic                             pc_hold,
    output logic                             pc_reset,
    output logic                             buf_lost,
    output logic                             io_hold,
    output logic [`LPM_NUM_PADS-1:0]         pad_pull_up,
    output logic [`LPM_NUM_PADS-1:0]         pad_pull_down,
    output logic [`LPM_NUM_PADS-1:0]         pad_gpio_en,
    output logic [2*`LPM_NUM_IFS-1:0]        if_drive,
    output logic [2:0]                       jtag_pull_up,
    output logic                             tck_pull_down
);

    logic [`LPM_NUM_WAKE-1:0] wake_raw;
    logic [`LPM_NUM_WAKE-1:0] wake_meta;
    logic [`LPM_NUM_WAKE-1:0] wake_sync;
    logic [`LPM_NUM_WAKE-1:0] wake_prev;
    logic [`LPM_NUM_WAKE-1:0] next_wake_meta;
    logic [`LPM_NUM_WAKE-1:0] next_wake_sync;
    logic [`LPM_NUM_WAKE-1:0] next_wake_prev;
    logic                     edge_wake;
    logic                     level_wake;

    lpm_pkg::lpm_state_e state;
    lpm_pkg::lpm_state_e next_state;
    logic                restart;
    logic                next_restart;
    logic                next_pc_reset;
    logic                next_buf_lost;
    logic [8:0]          ctl_out;
    logic [8:0]          next_ctl_out;
    logic                cfg_clear;
    logic                cfg_open;

    assign wake_raw = {parallel_control_line_zero, uart_cts, vbus_det, otg_id, usb_dm, usb_dp};

    // two-flop synchroniser, then a third stage for transition detection
    always_comb begin
        next_wake_meta = wake_meta;
        next_wake_sync = wake_sync;
        next_wake_prev = wake_prev;
        if (clk_en) begin
            next_wake_meta = wake_raw;
            next_wake_sync = wake_meta;
            next_wake_prev = wake_sync;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_meta <= '0;
            wake_sync <= '0;
            wake_prev <= '0;
        end else begin
            wake_meta <= next_wake_meta;
            wake_sync <= next_wake_sync;
            wake_prev <= next_wake_prev;
        end
    end

    // dp, dm and id wake from deep suspend only, on any transition; vbus, cts and control line zero on level
    assign edge_wake  = |((wake_sync ^ wake_prev) & `LPM_EDGE_MASK);
    assign level_wake = wake_sync[`LPM_WAKE_VBUS]
                      | (wake_sync[`LPM_WAKE_CTS] == lnk.cts_pol)
                      | wake_sync[`LPM_WAKE_CTL0];

    // requests only taken in normal mode with the core powered
    assign lnk.req_ready = (state == lpm_pkg::LPM_NORMAL) && lnk.core_vdd_on;

    always_comb begin
        next_state    = state;
        next_restart  = restart;
        next_pc_reset = 1'b0;
        next_buf_lost = buf_lost;
        if (clk_en) begin
            case (state)
                lpm_pkg::LPM_NORMAL: begin
                    if (!lnk.core_vdd_on) begin
                        next_state = lpm_pkg::LPM_PWRDN;
                    end else if (lnk.req_valid && lnk.req_mode == lpm_pkg::LPM_DEEP) begin
                        next_state = lpm_pkg::LPM_DEEP;
                    end else if (lnk.req_valid && lnk.req_mode == lpm_pkg::LPM_STANDBY) begin
                        next_state    = lpm_pkg::LPM_STANDBY;
                        next_buf_lost = 1'b1;
                    end
                end
                lpm_pkg::LPM_DEEP: begin
                    if (!lnk.core_vdd_on) begin
                        next_state = lpm_pkg::LPM_PWRDN;
                    end else if (edge_wake || level_wake) begin
                        next_state   = lpm_pkg::LPM_NORMAL;
                        next_restart = 1'b0;
                    end
                end
                lpm_pkg::LPM_STANDBY: begin
                    if (!lnk.core_vdd_on) begin
                        next_state = lpm_pkg::LPM_PWRDN;
                    end else if (level_wake) begin
                        next_state    = lpm_pkg::LPM_NORMAL;
                        next_restart  = 1'b1;
                        next_pc_reset = 1'b1;
                    end
                end
                lpm_pkg::LPM_PWRDN: begin
                    next_buf_lost = 1'b1;
                    if (lnk.core_vdd_on) begin
                        next_state    = lpm_pkg::LPM_NORMAL;
                        next_restart  = 1'b1;
                        next_pc_reset = 1'b1;
                    end
                end
                default: begin
                    next_state = lpm_pkg::LPM_NORMAL;
                end
            endcase
            if (next_state == lpm_pkg::LPM_DEEP || lnk.req_valid) begin
                next_buf_lost = next_buf_lost && (next_state != lpm_pkg::LPM_NORMAL
                                                  || state == lpm_pkg::LPM_NORMAL);
            end
        end
    end

    // power-domain controls, all derived from the coming state
    always_comb begin
        next_ctl_out = ctl_out;
        if (clk_en) begin
            next_ctl_out[0] = (next_state == lpm_pkg::LPM_NORMAL);
            next_ctl_out[1] = (next_state == lpm_pkg::LPM_DEEP);
            next_ctl_out[2] = (next_state == lpm_pkg::LPM_NORMAL);
            next_ctl_out[3] = (next_state == lpm_pkg::LPM_NORMAL);
            next_ctl_out[4] = (next_state == lpm_pkg::LPM_NORMAL) || (next_state == lpm_pkg::LPM_DEEP);
            next_ctl_out[5] = (next_state == lpm_pkg::LPM_NORMAL) || (next_state == lpm_pkg::LPM_DEEP);
            next_ctl_out[6] = (next_state == lpm_pkg::LPM_NORMAL) || (next_state == lpm_pkg::LPM_DEEP);
            next_ctl_out[7] = (next_state == lpm_pkg::LPM_DEEP);
            next_ctl_out[8] = (next_state != lpm_pkg::LPM_NORMAL);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state    <= lpm_pkg::LPM_NORMAL;
            restart  <= 1'b1;
            pc_reset <= 1'b0;
            buf_lost <= 1'b0;
            ctl_out  <= 9'h07d;
        end else begin
            state    <= next_state;
            restart  <= next_restart;
            pc_reset <= next_pc_reset;
            buf_lost <= next_buf_lost;
            ctl_out  <= next_ctl_out;
        end
    end

    assign usb3_phy_en = ctl_out[0];
    assign usb_suspend = ctl_out[1];
    assign clk_run     = ctl_out[2];
    assign pll_en      = ctl_out[3];
    assign xtal_en     = ctl_out[4];
    assign usb_xcvr_en = ctl_out[5];
    assign cpu_pwr_en  = ctl_out[6];
    assign pc_hold     = ctl_out[7];
    assign io_hold     = ctl_out[8];

    assign lnk.pwr_state    = state;
    assign lnk.woke_restart = restart;

    // configuration survives deep suspend and standby, is lost without core supply
    assign cfg_clear = (state == lpm_pkg::LPM_PWRDN);
    assign cfg_open  = clk_en && (state == lpm_pkg::LPM_NORMAL);

    for (genvar i = 0; i < `LPM_NUM_PADS; i++) begin : g_pad
        lpm_pkg::lpm_pull_e pull;
        lpm_pkg::lpm_pull_e next_pull;
        logic               gpio;
        logic               next_gpio;

        always_comb begin
            next_pull = pull;
            next_gpio = gpio;
            if (clk_en && cfg_clear) begin
                next_pull = lpm_pkg::lpm_pull_e'(`LPM_PULL_RST);
                next_gpio = `LPM_GPIO_RST;
            end else if (cfg_open && lnk.pad_we && lnk.pad_idx == `LPM_PAD_IDX_W'(i)) begin
                if (lnk.pad_pull != lpm_pkg::LPM_PULL_RSVD) begin
                    next_pull = lnk.pad_pull;
                end
                next_gpio = lnk.pad_gpio && (`LPM_PAD_IDX_W'(i) != `LPM_CTL15_IDX);
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                pull <= lpm_pkg::lpm_pull_e'(`LPM_PULL_RST);
                gpio <= `LPM_GPIO_RST;
            end else begin
                pull <= next_pull;
                gpio <= next_gpio;
            end
        end

        assign pad_pull_up[i]   = (pull == lpm_pkg::LPM_PULL_UP);
        assign pad_pull_down[i] = (pull == lpm_pkg::LPM_PULL_DOWN);
        assign pad_gpio_en[i]   = gpio;
    end

    for (genvar k = 0; k < `LPM_NUM_IFS; k++) begin : g_drv
        lpm_pkg::lpm_drive_e drv;
        lpm_pkg::lpm_drive_e next_drv;

        always_comb begin
            next_drv = drv;
            if (clk_en && cfg_clear) begin
                next_drv = lpm_pkg::lpm_drive_e'(`LPM_DRV_RST);
            end else if (cfg_open && lnk.drv_we && lnk.drv_sel == `LPM_IF_IDX_W'(k)) begin
                next_drv = lnk.drv_val;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                drv <= lpm_pkg::lpm_drive_e'(`LPM_DRV_RST);
            end else begin
                drv <= next_drv;
            end
        end

        assign if_drive[2*k+1:2*k] = drv;
    end

    // tdi, tms, trst pulls and tck pull-down cannot be configured
    assign jtag_pull_up  = `LPM_JTAG_PU;
    assign tck_pull_down = 1'b1;

endmodule : lpm_dev

/* common/lpm_map.svh */
/*
 * Constants of the low-power mode controller: pad counts, pad indices, reset values.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH

// pads 0..15 are parallel-interface control lines, 16..19 serial-peripheral pins
`define LPM_NUM_PADS      20
`define LPM_PAD_IDX_W     5
`define LPM_CTL15_IDX     5'h0f
`define LPM_NUM_IFS       4
`define LPM_IF_IDX_W      2
`define LPM_NUM_WAKE      6
`define LPM_WAKE_DP       0
`define LPM_WAKE_DM       1
`define LPM_WAKE_OTG_ID   2
`define LPM_WAKE_VBUS     3
`define LPM_WAKE_CTS      4
`define LPM_WAKE_CTL0     5
`define LPM_EDGE_MASK     6'h07
`define LPM_PULL_RST      2'h0
`define LPM_DRV_RST       2'h0
`define LPM_GPIO_RST      1'h0
`define LPM_JTAG_PU       3'h7

`endif

/* common/lpm_pkg.sv */
/*
 * Types of the low-power mode controller: power states, pad pulls, drive strengths, host states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lpm_pkg;

    typedef enum logic [1:0] {
        LPM_NORMAL  = 2'h0,
        LPM_DEEP    = 2'h1,
        LPM_STANDBY = 2'h2,
        LPM_PWRDN   = 2'h3
    } lpm_state_e;

    typedef enum logic [1:0] {
        LPM_PULL_NONE = 2'h0,
        LPM_PULL_UP   = 2'h1,
        LPM_PULL_DOWN = 2'h2,
        LPM_PULL_RSVD = 2'h3
    } lpm_pull_e;

    typedef enum logic [1:0] {
        LPM_DRV_FULL    = 2'h0,
        LPM_DRV_THREE_Q = 2'h1,
        LPM_DRV_HALF    = 2'h2,
        LPM_DRV_QUARTER = 2'h3
    } lpm_drive_e;

    typedef enum logic [1:0] {
        LPM_H_INIT = 2'h0,
        LPM_H_IDLE = 2'h1,
        LPM_H_REQ  = 2'h2,
        LPM_H_RSVD = 2'h3
    } lpm_host_state_e;

endpackage : lpm_pkg

/* common/lpm_if.sv */
/*
 * Link between the mode requester and the low-power mode controller.
 * Assumes both ends run on the same ref_clk.
 */
`include "lpm_map.svh"

interface lpm_if;
    logic                       req_valid;
    lpm_pkg::lpm_state_e        req_mode;
    logic                       req_ready;
    logic                       cts_pol;
    logic                       core_vdd_on;
    logic                       pad_we;
    logic [`LPM_PAD_IDX_W-1:0]  pad_idx;
    lpm_pkg::lpm_pull_e         pad_pull;
    logic                       pad_gpio;
    logic                       drv_we;
    logic [`LPM_IF_IDX_W-1:0]   drv_sel;
    lpm_pkg::lpm_drive_e        drv_val;
    lpm_pkg::lpm_state_e        pwr_state;
    logic                       woke_restart;

    modport dev (
        input  req_valid, req_mode, cts_pol, core_vdd_on, pad_we, pad_idx, pad_pull, pad_gpio,
        input  drv_we, drv_sel, drv_val,
        output req_ready, pwr_state, woke_restart
    );

    modport host (
        output req_valid, req_mode, cts_pol, core_vdd_on, pad_we, pad_idx, pad_pull, pad_gpio,
        output drv_we, drv_sel, drv_val,
        input  req_ready, pwr_state, woke_restart
    );
endinterface : lpm_if

/* logic/lpm_host.sv */
/*
 * Requesting end: pulls up unused pads after reset, forwards pad and drive settings,
 * issues mode requests once the datapath is quiet, drives the core supply control
 * and reports restart (after standby) or reload (after power-down) on wake.
 * Assumes the controller end on the same ref_clk through lpm_if.
 */
`include "lpm_map.svh"

module lpm_host (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    lpm_if.host                              lnk,
    input  wire logic [`LPM_NUM_PADS-1:0]    unused_mask,
    input  wire logic                        cmd_valid,
    input  wire lpm_pkg::lpm_state_e         cmd_mode,
    output logic                             cmd_ready,
    input  wire logic                        txn_idle,
    input  wire logic                        buf_drained,
    input  wire logic                        cts_pol_cfg,
    input  wire logic                        supply_off,
    input  wire logic                        cfg_valid,
    input  wire logic [`LPM_PAD_IDX_W-1:0]   cfg_idx,
    input  wire lpm_pkg::lpm_pull_e          cfg_pull,
    input  wire logic                        cfg_gpio,
    input  wire logic                        drv_valid,
    input  wire logic [`LPM_IF_IDX_W-1:0]    drv_sel,
    input  wire lpm_pkg::lpm_drive_e         drv_val,
    output logic                             cfg_ready,
    output logic                             fw_restart,
    output logic                             fw_reload
);

    lpm_pkg::lpm_host_state_e hs;
    lpm_pkg::lpm_host_state_e next_hs;
    logic [`LPM_PAD_IDX_W-1:0] idx;
    logic [`LPM_PAD_IDX_W-1:0] next_idx;
    lpm_pkg::lpm_state_e       next_mode;
    logic                      next_req;
    logic                      next_pad_we;
    logic [`LPM_PAD_IDX_W-1:0] next_pad_idx;
    lpm_pkg::lpm_pull_e        next_pad_pull;
    logic                      next_pad_gpio;
    logic                      next_drv_we;
    logic [`LPM_IF_IDX_W-1:0]  next_drv_sel;
    lpm_pkg::lpm_drive_e       next_drv_val;
    lpm_pkg::lpm_state_e       prev_state;
    logic                      next_restart_ev;
    logic                      next_reload_ev;
    logic                      cmd_ok;

    // suspend only with the datapath idle, standby only once buffers are read out
    assign cmd_ok    = txn_idle && (cmd_mode != lpm_pkg::LPM_STANDBY || buf_drained);
    assign cmd_ready = (hs == lpm_pkg::LPM_H_IDLE) && cmd_ok && clk_en;
    assign cfg_ready = (hs == lpm_pkg::LPM_H_IDLE) && (lnk.pwr_state == lpm_pkg::LPM_NORMAL) && clk_en;

    always_comb begin
        next_hs       = hs;
        next_idx      = idx;
        next_req      = lnk.req_valid;
        next_mode     = lnk.req_mode;
        next_pad_we   = 1'b0;
        next_pad_idx  = lnk.pad_idx;
        next_pad_pull = lnk.pad_pull;
        next_pad_gpio = lnk.pad_gpio;
        next_drv_we   = 1'b0;
        next_drv_sel  = lnk.drv_sel;
        next_drv_val  = lnk.drv_val;
        if (!clk_en) begin
            next_pad_we = lnk.pad_we;
            next_drv_we = lnk.drv_we;
        end else begin
            case (hs)
                lpm_pkg::LPM_H_INIT: begin
                    next_pad_we   = 1'b1;
                    next_pad_idx  = idx;
                    next_pad_pull = unused_mask[idx] ? lpm_pkg::LPM_PULL_UP : lpm_pkg::LPM_PULL_NONE;
                    next_pad_gpio = 1'b0;
                    next_idx      = idx + `LPM_PAD_IDX_W'(1);
                    if (idx == `LPM_PAD_IDX_W'(`LPM_NUM_PADS - 1)) begin
                        next_hs = lpm_pkg::LPM_H_IDLE;
                    end
                end
                lpm_pkg::LPM_H_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        next_req  = 1'b1;
                        next_mode = cmd_mode;
                        next_hs   = lpm_pkg::LPM_H_REQ;
                    end else if (cfg_valid && cfg_ready) begin
                        next_pad_we   = 1'b1;
                        next_pad_idx  = cfg_idx;
                        next_pad_pull = cfg_pull;
                        next_pad_gpio = cfg_gpio;
                    end else if (drv_valid && cfg_ready) begin
                        next_drv_we  = 1'b1;
                        next_drv_sel = drv_sel;
                        next_drv_val = drv_val;
                    end
                end
                lpm_pkg::LPM_H_REQ: begin
                    if (lnk.req_valid && lnk.req_ready) begin
                        next_req = 1'b0;
                        next_hs  = lpm_pkg::LPM_H_IDLE;
                    end
                end
                default: begin
                    next_hs = lpm_pkg::LPM_H_IDLE;
                end
            endcase
        end
    end

    // wake reporting: resume keeps the program, restart and reload do not
    always_comb begin
        next_restart_ev = 1'b0;
        next_reload_ev  = 1'b0;
        if (clk_en && lnk.pwr_state == lpm_pkg::LPM_NORMAL) begin
            next_restart_ev = (prev_state == lpm_pkg::LPM_STANDBY);
            next_reload_ev  = (prev_state == lpm_pkg::LPM_PWRDN);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hs              <= lpm_pkg::LPM_H_INIT;
            idx             <= '0;
            lnk.req_valid   <= 1'b0;
            lnk.req_mode    <= lpm_pkg::LPM_NORMAL;
            lnk.pad_we      <= 1'b0;
            lnk.pad_idx     <= '0;
            lnk.pad_pull    <= lpm_pkg::LPM_PULL_NONE;
            lnk.pad_gpio    <= 1'b0;
            lnk.drv_we      <= 1'b0;
            lnk.drv_sel     <= '0;
            lnk.drv_val     <= lpm_pkg::LPM_DRV_FULL;
            lnk.cts_pol     <= 1'b0;
            lnk.core_vdd_on <= 1'b1;
            prev_state      <= lpm_pkg::LPM_NORMAL;
            fw_restart      <= 1'b0;
            fw_reload       <= 1'b0;
        end else begin
            hs            <= next_hs;
            idx           <= next_idx;
            lnk.req_valid <= next_req;
            lnk.req_mode  <= next_mode;
            lnk.pad_we    <= next_pad_we;
            lnk.pad_idx   <= next_pad_idx;
            lnk.pad_pull  <= next_pad_pull;
            lnk.pad_gpio  <= next_pad_gpio;
            lnk.drv_we    <= next_drv_we;
            lnk.drv_sel   <= next_drv_sel;
            lnk.drv_val   <= next_drv_val;
            fw_restart    <= next_restart_ev;
            fw_reload     <= next_reload_ev;
            if (clk_en) begin
                lnk.cts_pol     <= cts_pol_cfg;
                lnk.core_vdd_on <= !supply_off;
                prev_state      <= lnk.pwr_state;
            end
        end
    end

endmodule : lpm_host

/* verif/lpm_link_asserts.sv */
/* checks on the mode link between requester and controller.
   assumes instantiation beside lpm_if, all on one ref_clk. */
module lpm_link_asserts (
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire logic                req_valid,
    input wire lpm_pkg::lpm_state_e req_mode,
    input wire logic                req_ready,
    input wire logic                core_vdd_on,
    input wire logic                pad_we,
    input wire lpm_pkg::lpm_state_e pwr_state,
    input wire logic                woke_restart
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic take = req_valid && req_ready;
    a_ready_when_normal: assert property (req_ready |-> pwr_state == lpm_pkg::LPM_NORMAL && core_vdd_on)
        else $error("ready outside normal");
    a_deep_entry: assert property (take && req_mode == lpm_pkg::LPM_DEEP |=> pwr_state == lpm_pkg::LPM_DEEP)
        else $error("deep not entered");
    a_standby_entry: assert property (take && req_mode == lpm_pkg::LPM_STANDBY |=> pwr_state == lpm_pkg::LPM_STANDBY)
        else $error("standby not entered");
    a_inert_modes: assert property (take && req_mode inside {lpm_pkg::LPM_NORMAL, lpm_pkg::LPM_PWRDN}
        |=> pwr_state == lpm_pkg::LPM_NORMAL)
        else $error("inert mode changed state");
    a_supply_loss: assert property (!core_vdd_on |=> pwr_state == lpm_pkg::LPM_PWRDN)
        else $error("no power down");
    a_supply_back: assert property (pwr_state == lpm_pkg::LPM_PWRDN && core_vdd_on |=> pwr_state == lpm_pkg::LPM_NORMAL)
        else $error("no exit from power down");
    a_deep_resume: assert property (pwr_state == lpm_pkg::LPM_NORMAL && $past(pwr_state) == lpm_pkg::LPM_DEEP |-> !woke_restart)
        else $error("deep wake restarted");
    a_standby_restart: assert property (pwr_state == lpm_pkg::LPM_NORMAL && $past(pwr_state) == lpm_pkg::LPM_STANDBY
        |-> woke_restart)
        else $error("standby wake resumed");
    a_request_drop: assert property (take |=> !req_valid)
        else $error("request held after take");
    c_deep: cover property (take && req_mode == lpm_pkg::LPM_DEEP);
    c_standby: cover property (take && req_mode == lpm_pkg::LPM_STANDBY);
    c_pwrdn: cover property (pwr_state == lpm_pkg::LPM_PWRDN);
    c_pad: cover property (pad_we);
endmodule : lpm_link_asserts

/* verif/testbench.sv */
/* self-checking bench: requester and controller joined by lpm_if.
   assumes the package, interface and design files compiled first. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, run, cmd_valid, cmd_ready, cfg_valid, cfg_gpio, drv_valid, cfg_ready, supply_off;
    logic usb3_phy_en, usb_suspend, clk_run, pll_en, xtal_en, usb_xcvr_en, cpu_pwr_en, pc_hold, pc_reset;
    logic buf_lost, io_hold, tck_pull_down;
    logic [19:0] pad_pull_up, pad_pull_down, pad_gpio_en;
    logic [7:0]  if_drive;
    logic [5:0]  w;
    logic [4:0]  cfg_idx;
    logic [2:0]  jtag_pull_up;
    logic [1:0]  drv_sel;
    lpm_pkg::lpm_state_e cmd_mode;
    lpm_pkg::lpm_pull_e  cfg_pull;
    lpm_pkg::lpm_drive_e drv_val;
    int err_total, comparisons, cyc;
    wire logic [8:0] pw = {usb3_phy_en, usb_suspend, clk_run, pll_en, xtal_en, usb_xcvr_en, cpu_pwr_en, pc_hold, io_hold};
    lpm_if lnk ();
    lpm_dev i_lpm_dev (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(run), .lnk(lnk), .usb_dp(w[0]), .usb_dm(w[1]),
        .otg_id(w[2]), .vbus_det(w[3]), .uart_cts(w[4]), .parallel_control_line_zero(w[5]),
        .usb3_phy_en(usb3_phy_en), .usb_suspend(usb_suspend), .clk_run(clk_run), .pll_en(pll_en), .xtal_en(xtal_en),
        .usb_xcvr_en(usb_xcvr_en), .cpu_pwr_en(cpu_pwr_en), .pc_hold(pc_hold), .pc_reset(pc_reset),
        .buf_lost(buf_lost), .io_hold(io_hold), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
        .pad_gpio_en(pad_gpio_en), .if_drive(if_drive), .jtag_pull_up(jtag_pull_up), .tck_pull_down(tck_pull_down));
    lpm_host i_lpm_host (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(run), .lnk(lnk), .unused_mask(20'h000f0),
        .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .cmd_ready(cmd_ready), .txn_idle(1'h1), .buf_drained(1'h1),
        .cts_pol_cfg(1'h1), .supply_off(supply_off), .cfg_valid(cfg_valid), .cfg_idx(cfg_idx), .cfg_pull(cfg_pull),
        .cfg_gpio(cfg_gpio), .drv_valid(drv_valid), .drv_sel(drv_sel), .drv_val(drv_val), .cfg_ready(cfg_ready),
        .fw_restart(), .fw_reload());
    lpm_link_asserts i_lpm_link_asserts (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(lnk.req_valid),
        .req_mode(lnk.req_mode), .req_ready(lnk.req_ready), .core_vdd_on(lnk.core_vdd_on), .pad_we(lnk.pad_we),
        .pwr_state(lnk.pwr_state), .woke_restart(lnk.woke_restart));
    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end
    task complete_run();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end
    task chk(input logic [23:0] g, input logic [23:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk
    task wt(input lpm_pkg::lpm_state_e s);
        for (int k = 0; k < 12 && lnk.pwr_state !== s; k++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(lnk.pwr_state, s, "power state");
    endtask : wt
    task go(input lpm_pkg::lpm_state_e s);
        repeat (4) @(posedge ref_clk);
        cmd_valid <= 1'h1;
        cmd_mode <= s;
        #1;
        for (int k = 0; k < 20 && cmd_ready !== 1'h1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        cmd_valid <= 1'h0;
        wt(s);
    endtask : go
    task cfg(input logic d, input logic [4:0] i, input lpm_pkg::lpm_pull_e p, input logic g,
             input lpm_pkg::lpm_drive_e v);
        @(posedge ref_clk);
        cfg_valid <= !d;
        drv_valid <= d;
        cfg_idx <= i;
        drv_sel <= i[1:0];
        cfg_pull <= p;
        cfg_gpio <= g;
        drv_val <= v;
        #1;
        for (int k = 0; k < 40 && cfg_ready !== 1'h1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        cfg_valid <= 1'h0;
        drv_valid <= 1'h0;
    endtask : cfg
    initial begin
        {rst_n, cmd_valid, cfg_valid, cfg_gpio, drv_valid, supply_off, w, cfg_idx, drv_sel} = '0;
        {run, cmd_mode, cfg_pull, drv_val} = {1'h1, lpm_pkg::LPM_NORMAL, lpm_pkg::LPM_PULL_NONE, lpm_pkg::LPM_DRV_FULL};
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (25) @(posedge ref_clk);
        #1;
        chk(pw, 9'h17c, "normal outputs");
        chk(pad_pull_up, 20'h000f0, "unused pulls");
        chk({jtag_pull_up, tck_pull_down}, 4'hf, "jtag pulls");
        cfg(1'h0, 5'h03, lpm_pkg::LPM_PULL_DOWN, 1'h1, lpm_pkg::LPM_DRV_FULL);
        cfg(1'h0, 5'h0f, lpm_pkg::LPM_PULL_UP, 1'h1, lpm_pkg::LPM_DRV_FULL);
        cfg(1'h1, 5'h02, lpm_pkg::LPM_PULL_NONE, 1'h0, lpm_pkg::LPM_DRV_QUARTER);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({pad_pull_down, if_drive[7:4]}, 24'h000083, "pull and drive");
        chk(pad_gpio_en, 20'h00008, "gpio select");
        go(lpm_pkg::LPM_NORMAL);
        for (int i = 0; i < 6; i++) begin
            go(lpm_pkg::LPM_DEEP);
            chk(pw, 9'h09f, "deep outputs");
            @(posedge ref_clk);
            w[i] <= ~w[i];
            wt(lpm_pkg::LPM_NORMAL);
            chk({lnk.woke_restart, pc_reset, pad_gpio_en}, 22'h000008, "resume");
            @(posedge ref_clk);
            w[5:3] <= 3'h0;
        end
        for (int i = 3; i < 6; i++) begin
            go(lpm_pkg::LPM_STANDBY);
            chk(pw, 9'h001, "standby outputs");
            @(posedge ref_clk);
            w[0] <= ~w[0];
            repeat (6) @(posedge ref_clk);
            #1;
            chk(lnk.pwr_state, lpm_pkg::LPM_STANDBY, "edge wake in standby");
            @(posedge ref_clk);
            w[i] <= 1'h1;
            wt(lpm_pkg::LPM_NORMAL);
            chk({lnk.woke_restart, pc_reset, buf_lost, pad_gpio_en}, 24'h700008, "restart");
            @(posedge ref_clk);
            w[5:3] <= 3'h0;
        end
        @(posedge ref_clk);
        supply_off <= 1'h1;
        wt(lpm_pkg::LPM_PWRDN);
        @(posedge ref_clk);
        supply_off <= 1'h0;
        wt(lpm_pkg::LPM_NORMAL);
        chk({lnk.woke_restart, pad_gpio_en}, 21'h100000, "config lost");
        complete_run();
    end
endmodule : testbench
